// *** design/uxm_regs.sv ***
/*
   Register bank for the upstream Memory 0 and I/O-or-Memory 1 translation windows and the MSI capability,
   with the translation of upstream addresses through both windows.
   Assumes a synchronous APB master on clock_i and a setup loader that drives the setup registers.
*/
`timescale 1ns/100ps
module uxm_regs
   import uxm_pkg::*;
(
   input  wire logic                         clock_i,
   input  wire logic                         reset_i,
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [uxm_pkg::UXM_ADDR_W-1:0] paddr_i,
   input  wire logic [uxm_pkg::UXM_DATA_W-1:0] pwdata_i,
   input  wire logic [uxm_pkg::UXM_STRB_W-1:0] pstrb_i,
   output logic      [uxm_pkg::UXM_DATA_W-1:0] prdata_o,
   output logic                              pready_o,
   output logic                              pslverr_o,
   input  wire logic                         setup_path_writable_i,
   input  wire logic                         setup_win_sel_i,
   input  wire logic [uxm_pkg::UXM_DATA_W-1:0] setup_data_i,
   input  wire logic                         intx_i,
   output logic                              msi_enable_o,
   output logic      [uxm_pkg::UXM_MME_W-1:0]  msi_msg_enable_o,
   output logic                              legacy_intx_o,
   input  wire logic                         up_valid_i,
   input  wire logic                         up_win_i,
   input  wire logic [uxm_pkg::UXM_DATA_W-1:0] up_addr_i,
   output logic                              xl_valid_o,
   output logic                              xl_hit_o,
   output logic      [uxm_pkg::UXM_DATA_W-1:0] xl_addr_o
);
   import uxm_pkg::*;

   logic [31:0] mem0_base;
   logic [31:0] mem0_setup;
   logic [31:0] win1_base;
   logic [31:0] win1_setup;
   logic [31:0] msi_ctrl;
   logic [31:0] msi_addr;
   logic [31:0] msi_data;

   wire logic        capture;
   wire logic        take;
   wire logic        wr_take;
   wire logic        hit_mem0_base;
   wire logic        hit_mem0_setup;
   wire logic        hit_win1_base;
   wire logic        hit_win1_setup;
   wire logic        hit_msi_ctrl;
   wire logic        hit_msi_addr;
   wire logic        hit_msi_data;
   wire logic        addr_hit;
   wire logic [31:0] mem0_size;
   wire logic [31:0] win1_size;
   wire logic [31:0] mem0_base_rd;
   wire logic [31:0] mem0_setup_rd;
   wire logic [31:0] win1_setup_rd;
   wire logic [31:0] msi_ctrl_rd;
   wire logic [31:0] rd_data;
   wire logic [31:0] mem0_xl_mask;
   wire logic [31:0] win1_xl_mask;
   wire logic [31:0] mem0_xl_addr;
   wire logic [31:0] win1_xl_addr;
   wire logic        mem0_xl_hit;
   wire logic        win1_xl_hit;
   wire logic [31:0] next_mem0_base;
   wire logic [31:0] next_mem0_setup;
   wire logic [31:0] next_win1_base;
   wire logic [31:0] next_win1_setup;
   wire logic [31:0] next_msi_ctrl;
   wire logic [31:0] next_msi_addr;
   wire logic [31:0] next_msi_data;
   wire logic        load_mem0;
   wire logic        load_win1;

   uxm_apb_slave u_apb
   (
      .clock_i   (clock_i),
      .reset_i   (reset_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pready_o  (pready_o),
      .capture_o (capture),
      .take_o    (take)
   );

   assign wr_take        = take & pwrite_i;
   assign hit_mem0_base  = (paddr_i == UXM_OFF_MEM0_BASE);
   assign hit_mem0_setup = (paddr_i == UXM_OFF_MEM0_SETUP);
   assign hit_win1_base  = (paddr_i == UXM_OFF_WIN1_BASE);
   assign hit_win1_setup = (paddr_i == UXM_OFF_WIN1_SETUP);
   assign hit_msi_ctrl   = (paddr_i == UXM_OFF_MSI_CTRL);
   assign hit_msi_addr   = (paddr_i == UXM_OFF_MSI_ADDR);
   assign hit_msi_data   = (paddr_i == UXM_OFF_MSI_DATA);
   assign addr_hit       = hit_mem0_base | hit_mem0_setup | hit_win1_base | hit_win1_setup
                         | hit_msi_ctrl | hit_msi_addr | hit_msi_data;

   // The size fields of the setup registers decide which base bits software may write; Window 1 base bit 31 is always writable.
   assign mem0_size     = mem0_setup & UXM_MEM0_SIZE_MASK;
   assign win1_size     = win1_setup & UXM_WIN1_SIZE_MASK;

   // Memory 0 base bits that the mask leaves read-only return ones, so the default setup reads as a 4KB window.
   assign mem0_base_rd  = mem0_base | (UXM_MEM0_BASE_BITS & ~mem0_size);
   assign mem0_setup_rd = mem0_setup | UXM_EN_MASK;
   assign win1_setup_rd = win1_setup;
   assign msi_ctrl_rd   = msi_ctrl | UXM_CAP_HEADER | UXM_MMC_FIELD;

   // Unmapped offsets answer zero together with an error.
   assign rd_data = hit_mem0_base  ? mem0_base_rd  :
                    hit_mem0_setup ? mem0_setup_rd :
                    hit_win1_base  ? win1_base     :
                    hit_win1_setup ? win1_setup_rd :
                    hit_msi_ctrl   ? msi_ctrl_rd   :
                    hit_msi_addr   ? msi_addr      :
                    hit_msi_data   ? msi_data      : UXM_ZERO;

   assign next_mem0_base = (wr_take & hit_mem0_base)
                         ? uxm_merge(mem0_base, pwdata_i, pstrb_i, mem0_size | UXM_TOP_BIT & UXM_ZERO)
                         : mem0_base;
   assign next_win1_base = (wr_take & hit_win1_base)
                         ? uxm_merge(win1_base, pwdata_i, pstrb_i, UXM_TOP_BIT | win1_size)
                         : win1_base;
   assign next_msi_ctrl  = (wr_take & hit_msi_ctrl)
                         ? uxm_merge(msi_ctrl, pwdata_i, pstrb_i, UXM_MCTL_WMASK)
                         : msi_ctrl;
   assign next_msi_addr  = (wr_take & hit_msi_addr)
                         ? uxm_merge(msi_addr, pwdata_i, pstrb_i, UXM_MADDR_WMASK)
                         : msi_addr;
   assign next_msi_data  = (wr_take & hit_msi_data)
                         ? uxm_merge(msi_data, pwdata_i, pstrb_i, UXM_MDATA_WMASK)
                         : msi_data;

   // Setup registers are read-only to the bus; only the setup loader changes them.
   assign load_mem0       = setup_path_writable_i & ~setup_win_sel_i;
   assign load_win1       = setup_path_writable_i & setup_win_sel_i;
   assign next_mem0_setup = load_mem0
                          ? ((setup_data_i & UXM_MEM0_LOAD_MASK) | UXM_EN_MASK)
                          : mem0_setup;
   assign next_win1_setup = load_win1
                          ? (setup_data_i & UXM_WIN1_LOAD_MASK)
                          : win1_setup;

   // The top base bit always takes part in translation since no size bit covers it.
   assign mem0_xl_mask = UXM_TOP_BIT | mem0_size;
   assign win1_xl_mask = UXM_TOP_BIT | win1_size;

   uxm_win_xlate u_xl_mem0
   (
      .addr_i   (up_addr_i),
      .base_i   (mem0_base),
      .mask_i   (mem0_xl_mask),
      .enable_i (mem0_setup[UXM_EN_BIT]),
      .addr_o   (mem0_xl_addr),
      .hit_o    (mem0_xl_hit)
   );

   uxm_win_xlate u_xl_win1
   (
      .addr_i   (up_addr_i),
      .base_i   (win1_base),
      .mask_i   (win1_xl_mask),
      .enable_i (win1_setup[UXM_EN_BIT]),
      .addr_o   (win1_xl_addr),
      .hit_o    (win1_xl_hit)
   );

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         mem0_base  <= UXM_REG_RESET;
         mem0_setup <= UXM_MEM0_SETUP_RST;
         win1_base  <= UXM_REG_RESET;
         win1_setup <= UXM_WIN1_SETUP_RST;
         msi_ctrl   <= UXM_MCTL_RESET;
         msi_addr   <= UXM_REG_RESET;
         msi_data   <= UXM_REG_RESET;
      end
      else
      begin
         mem0_base  <= next_mem0_base;
         mem0_setup <= next_mem0_setup;
         win1_base  <= next_win1_base;
         win1_setup <= next_win1_setup;
         msi_ctrl   <= next_msi_ctrl;
         msi_addr   <= next_msi_addr;
         msi_data   <= next_msi_data;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         prdata_o  <= UXM_ZERO;
         pslverr_o <= 1'b0;
      end
      else if (capture)
      begin
         prdata_o  <= pwrite_i ? UXM_ZERO : rd_data;
         pslverr_o <= ~addr_hit;
      end
   end

   // Legacy INTx is forwarded only while MSI is off; the outputs lag the register by one cycle.
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         msi_enable_o     <= 1'b0;
         msi_msg_enable_o <= UXM_MMC_VALUE;
         legacy_intx_o    <= 1'b0;
      end
      else
      begin
         msi_enable_o     <= msi_ctrl[UXM_MSI_EN_BIT];
         msi_msg_enable_o <= msi_ctrl[UXM_MME_LO +: UXM_MME_W];
         legacy_intx_o    <= intx_i & ~msi_ctrl[UXM_MSI_EN_BIT];
      end
   end

   // Window 1 is chosen by up_win_i, Memory 0 otherwise.
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         xl_valid_o <= 1'b0;
         xl_hit_o   <= 1'b0;
         xl_addr_o  <= UXM_ZERO;
      end
      else
      begin
         xl_valid_o <= up_valid_i;
         xl_hit_o   <= up_valid_i & (up_win_i ? win1_xl_hit : mem0_xl_hit);
         xl_addr_o  <= up_win_i ? win1_xl_addr : mem0_xl_addr;
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   sequence s_setup_phase;
      psel_i && !penable_i && !pready_o;
   endsequence

   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence

   a_apb_answer_time: assert property (s_setup_phase |=> s_answer)
      else $error("ready did not pulse one cycle after setup");

   a_mem0_enable_one: assert property (capture && hit_mem0_setup && !pwrite_i |=> prdata_o[UXM_EN_BIT])
      else $error("memory 0 enable read back as zero");

   a_type_reads_zero: assert property (capture && (hit_mem0_setup || hit_win1_setup) |=> !prdata_o[UXM_TYPE_BIT])
      else $error("type selector read back as one");

   a_cap_header_val: assert property (capture && hit_msi_ctrl && !pwrite_i
                                      |=> prdata_o[15:0] == UXM_CAP_HEADER[15:0]
                                          && prdata_o[UXM_MMC_LO +: UXM_MME_W] == UXM_MMC_VALUE)
      else $error("capability header or message capable field wrong");

   a_setup_bus_ro: assert property (wr_take && (hit_mem0_setup || hit_win1_setup) && !setup_path_writable_i
                                    |=> $stable(mem0_setup) && $stable(win1_setup))
      else $error("bus write changed a setup register");

   a_base_ro_bits: assert property (wr_take && hit_win1_base
                                    |=> ((win1_base ^ $past(win1_base)) & ~$past(win1_xl_mask)) == UXM_ZERO)
      else $error("read-only base bit changed on write");

   a_unmapped_err: assert property (capture && !addr_hit |=> pslverr_o && prdata_o == UXM_ZERO ##1 !pready_o)
      else $error("unmapped offset not answered with error and zero");

   a_msi_gates_intx: assert property (msi_ctrl[UXM_MSI_EN_BIT] |=> !legacy_intx_o)
      else $error("legacy interrupt passed while messages enabled");

   a_xlate_mem0: assert property (up_valid_i && !up_win_i
                                  |=> xl_hit_o && xl_addr_o == (($past(up_addr_i) & ~$past(mem0_xl_mask))
                                                                | ($past(mem0_base) & $past(mem0_xl_mask))))
      else $error("memory 0 translation wrong");

   a_win1_disabled: assert property (up_valid_i && up_win_i && !win1_setup[UXM_EN_BIT]
                                     |=> !xl_hit_o && xl_addr_o == $past(up_addr_i))
      else $error("disabled window 1 translated an address");

endmodule

// *** inc/uxm_pkg.sv ***
/*
   Shared constants, types and helper functions for the upstream translation and MSI register bank.
   Assumes a 12-bit configuration offset space reached over a 32-bit APB bus.
*/
package uxm_pkg;

   localparam int          UXM_ADDR_W          = 12;
   localparam int          UXM_DATA_W          = 32;
   localparam int          UXM_STRB_W          = 4;
   localparam int          UXM_MME_W           = 3;

   localparam logic [11:0] UXM_OFF_MEM0_BASE   = 12'h0e0;
   localparam logic [11:0] UXM_OFF_MEM0_SETUP  = 12'h0e4;
   localparam logic [11:0] UXM_OFF_WIN1_BASE   = 12'h0e8;
   localparam logic [11:0] UXM_OFF_WIN1_SETUP  = 12'h0ec;
   localparam logic [11:0] UXM_OFF_MSI_CTRL    = 12'h0f0;
   localparam logic [11:0] UXM_OFF_MSI_ADDR    = 12'h0f4;
   localparam logic [11:0] UXM_OFF_MSI_DATA    = 12'h0fc;

   localparam int          UXM_TYPE_BIT        = 0;
   localparam int          UXM_EN_BIT          = 31;
   localparam int          UXM_MSI_EN_BIT      = 16;
   localparam int          UXM_MME_LO          = 20;

   localparam logic [31:0] UXM_ZERO            = 32'h00000000;
   localparam logic [31:0] UXM_TOP_BIT         = 32'h80000000;
   localparam logic [31:0] UXM_EN_MASK         = 32'h80000000;
   localparam logic [31:0] UXM_MEM0_SIZE_MASK  = 32'h7ffff000;
   localparam logic [31:0] UXM_WIN1_SIZE_MASK  = 32'h7fffffc0;
   localparam logic [31:0] UXM_MEM0_BASE_BITS  = 32'hfffff000;
   localparam logic [31:0] UXM_WIN1_BASE_BITS  = 32'hffffffc0;
   localparam logic [31:0] UXM_MEM0_LOAD_MASK  = 32'h7ffff00e;
   localparam logic [31:0] UXM_WIN1_LOAD_MASK  = 32'hffffffce;
   localparam logic [31:0] UXM_MCTL_WMASK      = 32'h00f10000;
   localparam logic [31:0] UXM_MADDR_WMASK     = 32'hfffffffc;
   localparam logic [31:0] UXM_MDATA_WMASK     = 32'h0000ffff;

   localparam logic [7:0]  UXM_MSI_CAP_ID      = 8'h05;
   localparam logic [7:0]  UXM_MSI_NEXT_PTR    = 8'h00;
   localparam logic [2:0]  UXM_MMC_VALUE       = 3'h0;
   localparam int          UXM_MMC_LO          = 17;
   localparam logic [31:0] UXM_CAP_HEADER      = {16'h0000, UXM_MSI_NEXT_PTR, UXM_MSI_CAP_ID};
   localparam logic [31:0] UXM_MMC_FIELD       = {12'h000, UXM_MMC_VALUE, 1'b0, 16'h0000};
   localparam logic [31:0] UXM_MCTL_RESET      = 32'h00800000;
   localparam logic [31:0] UXM_MEM0_SETUP_RST  = 32'h80000000;
   localparam logic [31:0] UXM_WIN1_SETUP_RST  = 32'h00000000;
   localparam logic [31:0] UXM_REG_RESET       = 32'h00000000;

   typedef enum logic [1:0]
   {
      UXM_ST_IDLE   = 2'b01,
      UXM_ST_ANSWER = 2'b10
   } uxm_apb_state_e;

   // Expands byte strobes to a bit mask and keeps bits outside the writable mask.
   function automatic logic [31:0] uxm_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb,
                                             input logic [31:0] wmask);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
      return (old_v & ~m) | (new_v & m);
   endfunction

endpackage

// *** design/uxm_apb_slave.sv ***
/*
   APB handshake for the register bank: no wait states, ready from a flip-flop.
   Assumes an APB master that holds its request until it samples pready high.
*/
`timescale 1ns/100ps
module uxm_apb_slave
   import uxm_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic psel_i,
   input  wire logic penable_i,
   output logic      pready_o,
   output logic      capture_o,
   output logic      take_o
);
   import uxm_pkg::*;

   uxm_apb_state_e state;
   uxm_apb_state_e next_state;

   // Read data is captured in the setup cycle so that it can leave from a flip-flop with ready.
   assign capture_o  = psel_i & ~penable_i & (state == UXM_ST_IDLE);
   assign take_o     = psel_i & penable_i & pready_o;
   assign next_state = capture_o ? UXM_ST_ANSWER : UXM_ST_IDLE;

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         state    <= UXM_ST_IDLE;
         pready_o <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         pready_o <= capture_o;
      end
   end

endmodule

// *** design/uxm_win_xlate.sv ***
/*
   Address translation of one upstream window.
   Assumes the caller has already decided that the access falls inside this window.
*/
`timescale 1ns/100ps
module uxm_win_xlate
   import uxm_pkg::*;
(
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] base_i,
   input  wire logic [31:0] mask_i,
   input  wire logic        enable_i,
   output logic      [31:0] addr_o,
   output logic             hit_o
);
   import uxm_pkg::*;

   // A disabled window passes the address through untouched.
   assign addr_o = enable_i ? ((addr_i & ~mask_i) | (base_i & mask_i)) : addr_i;
   assign hit_o  = enable_i;

endmodule

// *** sim/uxm_host_model.sv ***
/*
   APB master standing in for the host configuration software.
   Assumes one clock; the bench calls xfer and keeps one transfer in flight at a time.
*/
`timescale 1ns/100ps
module uxm_host_model
(
   input  wire logic        clock_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [11:0]      paddr_o,
   output logic [31:0]      pwdata_o,
   output logic [3:0]       pstrb_o,
   input  wire logic        pready_i
);
   initial
   begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = 12'h000;
      pwdata_o  = 32'h00000000;
      pstrb_o   = 4'h0;
   end

   // Idle gaps make a slow host; released data is inverted so a stale value never looks held.
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input int gap);
      repeat (gap + 1) @(posedge clock_i);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= wr;
      paddr_o   <= a;
      pwdata_o  <= d;
      pstrb_o   <= s;
      @(posedge clock_i);
      penable_o <= 1'b1;
      do @(posedge clock_i); while (pready_i !== 1'b1);
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o  <= ~d;
   endtask
endmodule

// *** sim/tb_upstream_xlate_msi_config_regs.sv ***
/*
   Self-checking bench for the upstream translation and MSI register bank.
   Assumes uxm_host_model drives APB; expectations queue up and a monitor compares them.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_upstream_xlate_msi_config_regs;
   import uxm_pkg::*;
   logic        clock_i, reset_i, psel, penable, pwrite, pready, pslverr, spw, ssel, intx;
   logic        msi_en, legacy, upv, upw, xlv, xlh;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, sdata, upa, xla, w, b0, e0, e4, e8, ec, m, wm;
   logic [3:0]  pstrb, s;
   logic [2:0]  mme;
   logic [32:0] apq[$], xq[$];
   int          error_cnt = 0;
   int          checks = 0;
   logic [11:0] ra[7] = '{UXM_OFF_MEM0_BASE, UXM_OFF_MEM0_SETUP, UXM_OFF_WIN1_BASE, UXM_OFF_WIN1_SETUP,
                          UXM_OFF_MSI_CTRL, UXM_OFF_MSI_ADDR, UXM_OFF_MSI_DATA};
   logic [31:0] rv[7] = '{32'hfffff000, 32'h80000000, 32'h0, 32'h0, 32'h00800005, 32'h0, 32'h0};

   uxm_host_model host_u
   (
      .clock_i   (clock_i),
      .psel_o    (psel),
      .penable_o (penable),
      .pwrite_o  (pwrite),
      .paddr_o   (paddr),
      .pwdata_o  (pwdata),
      .pstrb_o   (pstrb),
      .pready_i  (pready)
   );

   uxm_regs dut_u
   (
      .clock_i               (clock_i),
      .reset_i               (reset_i),
      .psel_i                (psel),
      .penable_i             (penable),
      .pwrite_i              (pwrite),
      .paddr_i               (paddr),
      .pwdata_i              (pwdata),
      .pstrb_i               (pstrb),
      .prdata_o              (prdata),
      .pready_o              (pready),
      .pslverr_o             (pslverr),
      .setup_path_writable_i (spw),
      .setup_win_sel_i       (ssel),
      .setup_data_i          (sdata),
      .intx_i                (intx),
      .msi_enable_o          (msi_en),
      .msi_msg_enable_o      (mme),
      .legacy_intx_o         (legacy),
      .up_valid_i            (upv),
      .up_win_i              (upw),
      .up_addr_i             (upa),
      .xl_valid_o            (xlv),
      .xl_hit_o              (xlh),
      .xl_addr_o             (xla)
   );

   function automatic logic [31:0] bm(input logic [3:0] st);
      return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] st, input logic e, input logic [31:0] x);
      apq.push_back({e, x});
      host_u.xfer(wr, a, d, st, $urandom_range(2));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0, 4'hf, 1'b0, x);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
      acc(1'b1, a, d, st, 1'b0, 32'h0);
   endtask

   task automatic load(input logic sel, input logic [31:0] d);
      @(posedge clock_i);
      spw   <= 1'b1;
      ssel  <= sel;
      sdata <= d;
      @(posedge clock_i);
      spw   <= 1'b0;
      sdata <= ~d;
   endtask

   task automatic xl(input logic win, input logic [31:0] a, input logic [31:0] st, input logic [31:0] base);
      logic [31:0] mk;
      mk = UXM_TOP_BIT | (st & (win ? UXM_WIN1_SIZE_MASK : UXM_MEM0_SIZE_MASK));
      xq.push_back(st[UXM_EN_BIT] ? {1'b1, (a & ~mk) | (base & mk)} : {1'b0, a});
      @(posedge clock_i);
      upv <= 1'b1;
      upw <= win;
      upa <= a;
      @(posedge clock_i);
      upv <= 1'b0;
      upa <= ~a;
   endtask

   task automatic rst();
      reset_i <= 1'b1;
      repeat (12) @(posedge clock_i);
      reset_i <= 1'b0;
      b0 = 32'h0;
      e8 = 32'h0;
      #1;
      `CHK({pready, pslverr, prdata, msi_en, mme, legacy, xlv, xlh, xla}, 73'h0)
      foreach (ra[i]) rd(ra[i], rv[i]);
      $display("reset test done");
   endtask

   always @(posedge clock_i)
   begin
      if (pready === 1'b1)
         `CHK({pslverr, prdata}, apq.pop_front())
      if (xlv === 1'b1)
         `CHK({xlh, xla}, xq.pop_front())
   end

   initial
   begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // The tests take a few hundred cycles; this leaves a wide margin.
   initial
   begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      reset_i = 1'b1;
      spw = 1'b0;
      ssel = 1'b0;
      sdata = 32'h0;
      intx = 1'b0;
      upv = 1'b0;
      upw = 1'b0;
      upa = 32'h0;
      void'($urandom(32'h2bf27a16));
      rst();
      acc(1'b0, 12'h0f8, 32'h0, 4'hf, 1'b1, 32'h0);
      acc(1'b1, 12'h000, 32'hffffffff, 4'hf, 1'b1, 32'h0);
      for (int c = 0; c < 8; c++)
      begin
         intx <= 1'($urandom);
         wr(UXM_OFF_MSI_CTRL, {8'hff, 1'b0, c[2:0], 3'h7, c[0], 16'hffff}, 4'hf);
         rd(UXM_OFF_MSI_CTRL, {8'h00, 1'b0, c[2:0], 3'h0, c[0], 16'h0005});
         repeat (3) @(posedge clock_i);
         `CHK(mme, c[2:0])
         `CHK({msi_en, legacy}, {c[0], intx & ~c[0]})
      end
      wr(UXM_OFF_MSI_ADDR, 32'hffffffff, 4'hf);
      acc(1'b1, 12'h0f8, 32'h0, 4'hf, 1'b1, 32'h0);
      rd(UXM_OFF_MSI_ADDR, 32'hfffffffc);
      w = $urandom;
      s = 4'($urandom);
      wr(UXM_OFF_MSI_DATA, w, s);
      rd(UXM_OFF_MSI_DATA, w & bm(s) & UXM_MDATA_WMASK);
      $display("msi test done");
      wr(UXM_OFF_MEM0_SETUP, 32'h0, 4'hf);
      wr(UXM_OFF_WIN1_SETUP, 32'hffffffff, 4'hf);
      rd(UXM_OFF_MEM0_SETUP, 32'h80000000);
      rd(UXM_OFF_WIN1_SETUP, 32'h0);
      xl(1'b1, $urandom, 32'h0, 32'h0);
      w = $urandom & ~UXM_EN_MASK;
      load(1'b0, w);
      e4 = (w & UXM_MEM0_LOAD_MASK) | UXM_EN_MASK;
      rd(UXM_OFF_MEM0_SETUP, e4);
      m = e4 & UXM_MEM0_SIZE_MASK;
      for (int k = 0; k < 4; k++)
      begin
         w = $urandom;
         s = 4'($urandom);
         wm = m & bm(s);
         b0 = (w & wm) | (b0 & ~wm);
         e0 = (b0 & m) | (UXM_MEM0_BASE_BITS & ~m);
         wr(UXM_OFF_MEM0_BASE, w, s);
         rd(UXM_OFF_MEM0_BASE, e0);
         // Translation uses the stored base; bits that only read back as ones are not stored.
         xl(1'b0, $urandom, e4, b0);
      end
      // A memory window keeps size bits 11:6 clear.
      w = ($urandom | UXM_EN_MASK) & ~32'h00000fc1;
      load(1'b1, w);
      ec = w & UXM_WIN1_LOAD_MASK;
      rd(UXM_OFF_WIN1_SETUP, ec);
      for (int k = 0; k < 4; k++)
      begin
         w = $urandom;
         s = 4'($urandom);
         wm = (UXM_TOP_BIT | (ec & UXM_WIN1_SIZE_MASK)) & bm(s);
         e8 = ((w & wm) | (e8 & ~wm)) & UXM_WIN1_BASE_BITS;
         wr(UXM_OFF_WIN1_BASE, w, s);
         rd(UXM_OFF_WIN1_BASE, e8);
         xl(1'b1, $urandom, ec, e8);
      end
      ec = ec & ~UXM_EN_MASK;
      load(1'b1, ec);
      xl(1'b1, $urandom, ec, e8);
      $display("window test done");
      rst();
      repeat (4) @(posedge clock_i);
      `CHK(apq.size() + xq.size(), 0)
      end_of_test();
   end
endmodule
